// ### srecc_pkg.sv
package srecc_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SYNC_STAGES = 3;
	// reset extension times, selected by reset_extension_select
	localparam int EXT0_NS = 1000;
	localparam int EXT1_NS = 2000;
	localparam int EXT2_NS = 4000;
	localparam int EXT3_NS = 8000;
	localparam int EXT0_CYC = (EXT0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXT1_CYC = (EXT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXT2_CYC = (EXT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXT3_CYC = (EXT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXT_CNT_W = 10;
	// own drive intent must be steady this long before its readback is compared
	localparam int INTENT_HIST = 5;
	localparam int DRIVE_HIST = 4;

	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_RESET = 3'h1,
		ST_DIAG = 3'h3,
		ST_ACTIVE = 3'h2,
		ST_SAFE = 3'h6
	} srecc_state_type;

	typedef enum logic [1:0] {
		OP_CFG_WRITE = 2'h0,
		OP_SW_RESET = 2'h1,
		OP_ENABLE = 2'h2,
		OP_CLEAR = 2'h3
	} srecc_op_type;

	// protected configuration bytes, in CRC feed order
	localparam int CFG_REGS = 16;
	localparam int IDX_DEVICE_CONFIG1 = 0;
	localparam int IDX_DEVICE_CONFIG4 = 3;
	localparam int IDX_SAFETY_CONFIG1 = 4;
	localparam int IDX_SAFETY_CONFIG2 = 5;
	localparam int IDX_SAFETY_CONFIG3 = 6;
	localparam int IDX_SAFETY_CONFIG4 = 7;
	localparam int IDX_SAFETY_CONFIG5 = 8;
	localparam logic [4:0] ADDR_CRC_EXPECTED = 5'h10;
	localparam logic [4:0] ADDR_CRC_CTRL = 5'h11;
	localparam logic [7:0] CFG_RESET_DEFAULT = 8'h00;
	localparam logic [7:0] CFG_RESET_SAFETY_CONFIG4 = 8'hF5;
	localparam int BIT_MISMATCH_RST = 0;
	localparam int BIT_MISMATCH_SAFE = 1;
	localparam int BIT_WD_RST_EN = 4;
	localparam int BIT_MON_RST_EN = 5;

	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	localparam logic [6:0] CRC_LAST_BIT = 7'h7F;

	localparam int FLAGS_W = 3;
	localparam int FLAG_MISMATCH = 0;
	localparam int FLAG_CRC = 1;
	localparam int FLAG_DRIVER = 2;

	// host Avalon-MM byte offsets and command word layout
	localparam logic [3:0] AV_CMD = 4'h0;
	localparam logic [3:0] AV_PIN = 4'h4;
	localparam logic [3:0] AV_STATUS = 4'h8;
	localparam int CMD_DATA_LSB = 0;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_OP_LSB = 16;
	localparam int STAT_RESET_PIN = 0;
	localparam int STAT_ENABLE_PIN = 1;
	localparam int STAT_FLAGS_LSB = 4;
endpackage

// ### srecc_link_if.sv
`timescale 1ns/1ps
interface srecc_link_if;
	import srecc_pkg::*;
	logic reset_dev_out;
	logic reset_dev_oe;
	logic reset_host_out;
	logic reset_host_oe;
	logic reset_level;
	logic enable_drive;
	logic enable_ext_low;
	logic enable_pin_level;
	logic cmd_valid;
	srecc_op_type cmd_op;
	logic [4:0] cmd_addr;
	logic [7:0] cmd_data;
	logic [FLAGS_W-1:0] dev_flags;

	// open-drain wire with internal pullup
	assign reset_level = ~((reset_dev_oe & ~reset_dev_out) | (reset_host_oe & ~reset_host_out));
	assign enable_pin_level = enable_drive & ~enable_ext_low;

	modport dev(
		output reset_dev_out,
		output reset_dev_oe,
		input reset_level,
		output enable_drive,
		input enable_pin_level,
		input cmd_valid,
		input cmd_op,
		input cmd_addr,
		input cmd_data,
		output dev_flags
	);
	modport host(
		output reset_host_out,
		output reset_host_oe,
		input reset_level,
		input enable_pin_level,
		output cmd_valid,
		output cmd_op,
		output cmd_addr,
		output cmd_data,
		input dev_flags
	);
endinterface

// ### srecc_host.sv
`timescale 1ns/1ps
module srecc_host (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	srecc_link_if.host link,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest
);
	import srecc_pkg::*;
	logic [SYNC_STAGES-1:0] rs_sync_reg;
	logic [SYNC_STAGES-1:0] en_sync_reg;
	logic rs_filt_reg;
	logic en_filt_reg;
	logic cmd_valid_reg;
	srecc_op_type cmd_op_reg;
	logic [4:0] cmd_addr_reg;
	logic [7:0] cmd_data_reg;
	logic force_low_reg;

	assign link.reset_host_out = 1'b0;
	assign link.reset_host_oe = force_low_reg;
	assign link.cmd_valid = cmd_valid_reg;
	assign link.cmd_op = cmd_op_reg;
	assign link.cmd_addr = cmd_addr_reg;
	assign link.cmd_data = cmd_data_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rs_sync_reg <= '1;
			en_sync_reg <= '0;
			rs_filt_reg <= 1'b1;
			en_filt_reg <= 1'b0;
		end else if (ce) begin
			rs_sync_reg <= {rs_sync_reg[SYNC_STAGES-2:0], link.reset_level};
			en_sync_reg <= {en_sync_reg[SYNC_STAGES-2:0], link.enable_pin_level};
			if (rs_sync_reg[1] == rs_sync_reg[2]) begin
				rs_filt_reg <= rs_sync_reg[2];
			end
			if (en_sync_reg[1] == en_sync_reg[2]) begin
				en_filt_reg <= en_sync_reg[2];
			end
		end
	end

	// every access answers at the second edge; waitrequest rests high
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
		end else if (ce) begin
			if ((avs_read | avs_write) & avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				avs_readdata <= 32'h0;
				if (avs_read & (avs_address == AV_PIN)) begin
					avs_readdata[0] <= force_low_reg;
				end else if (avs_read & (avs_address == AV_STATUS)) begin
					avs_readdata[STAT_RESET_PIN] <= rs_filt_reg;
					avs_readdata[STAT_ENABLE_PIN] <= en_filt_reg;
					avs_readdata[STAT_FLAGS_LSB +: FLAGS_W] <= link.dev_flags;
				end
			end else begin
				avs_waitrequest <= 1'b1;
			end
		end
	end

	// software reset, enable and config orders go out as one-cycle commands
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cmd_valid_reg <= 1'b0;
			cmd_op_reg <= OP_CFG_WRITE;
			cmd_addr_reg <= 5'h00;
			cmd_data_reg <= 8'h00;
			force_low_reg <= 1'b0;
		end else if (ce) begin
			cmd_valid_reg <= 1'b0;
			// a write lands only at the edge that completes the access
			if (avs_write & ~avs_waitrequest) begin
				if (avs_address == AV_CMD) begin
					cmd_valid_reg <= 1'b1;
					cmd_op_reg <= srecc_op_type'(avs_writedata[CMD_OP_LSB +: 2]);
					cmd_addr_reg <= avs_writedata[CMD_ADDR_LSB +: 5];
					cmd_data_reg <= avs_writedata[CMD_DATA_LSB +: 8];
				end else if (avs_address == AV_PIN) begin
					force_low_reg <= avs_writedata[0];
				end
			end
		end
	end
endmodule

// ### srecc_device.sv
// The register addresses and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module srecc_device (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	srecc_link_if.dev link,
	input wire srecc_pkg::srecc_state_type dev_state,
	input wire logic power_on_reset_event,
	input wire logic [4:0] uv_events,
	input wire logic [4:0] ov_events,
	input wire logic [3:0] wdog_fail_count,
	input wire logic [3:0] error_signal_monitor_fail_count,
	input wire logic analog_builtin_self_test,
	output logic reset_request,
	output logic safe_request,
	output logic enable_out_ctrl,
	output logic [srecc_pkg::FLAGS_W-1:0] status_flags
);
	import srecc_pkg::*;

	function automatic logic [7:0] cfg_reset_value(input int idx);
		cfg_reset_value = (idx == IDX_SAFETY_CONFIG4) ? CFG_RESET_SAFETY_CONFIG4 : CFG_RESET_DEFAULT;
	endfunction

	logic [7:0] cfg_reg [CFG_REGS];
	logic [7:0] crc_expected_reg;
	logic crc_enable_reg;
	logic [SYNC_STAGES-1:0] rs_sync_reg;
	logic [SYNC_STAGES-1:0] en_sync_reg;
	logic rs_filt_reg;
	logic en_filt_reg;
	logic reset_oe_reg;
	logic [EXT_CNT_W-1:0] ext_cnt_reg;
	logic [INTENT_HIST-1:0] intent_hist_reg;
	logic enable_drive_reg;
	logic [DRIVE_HIST-1:0] drive_hist_reg;
	logic [7:0] crc_reg;
	logic [6:0] crc_bit_reg;
	logic crc_fail_reg;
	logic [FLAGS_W-1:0] flags_reg;
	logic safe_req_reg;

	logic in_diag;
	logic in_run;
	logic cfg_write;
	logic [1:0] ext_sel;
	logic mm_rst_en;
	logic mm_safe_en;
	logic intent_stable;
	logic mismatch;
	logic warm_reset;
	logic reset_source;
	logic [EXT_CNT_W-1:0] ext_load;
	logic crc_in_bit;
	logic [7:0] crc_next;
	logic driver_error;
	logic [FLAGS_W-1:0] flag_set;
	logic [FLAGS_W-1:0] flag_clr;

	assign in_diag = dev_state == ST_DIAG;
	assign in_run = in_diag | (dev_state == ST_ACTIVE);
	assign cfg_write = link.cmd_valid & (link.cmd_op == OP_CFG_WRITE) & in_diag;
	assign ext_sel = cfg_reg[IDX_DEVICE_CONFIG4][1:0];
	assign mm_rst_en = cfg_reg[IDX_SAFETY_CONFIG2][BIT_MISMATCH_RST];
	assign mm_safe_en = cfg_reg[IDX_SAFETY_CONFIG2][BIT_MISMATCH_SAFE];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < CFG_REGS; i++) begin
				cfg_reg[i] <= cfg_reset_value(i);
			end
			crc_expected_reg <= 8'h00;
			crc_enable_reg <= 1'b0;
		end else if (ce && cfg_write) begin
			if (!link.cmd_addr[4]) begin
				cfg_reg[link.cmd_addr[3:0]] <= link.cmd_data;
			end else if (link.cmd_addr == ADDR_CRC_EXPECTED) begin
				crc_expected_reg <= link.cmd_data;
			end else if (link.cmd_addr == ADDR_CRC_CTRL) begin
				crc_enable_reg <= link.cmd_data[0];
			end
		end
	end

	// pin readbacks: three stages, a change counts when stages two and three agree
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rs_sync_reg <= '0;
			en_sync_reg <= '0;
			rs_filt_reg <= 1'b0;
			en_filt_reg <= 1'b0;
		end else if (ce) begin
			rs_sync_reg <= {rs_sync_reg[SYNC_STAGES-2:0], link.reset_level};
			en_sync_reg <= {en_sync_reg[SYNC_STAGES-2:0], link.enable_pin_level};
			if (rs_sync_reg[1] == rs_sync_reg[2]) begin
				rs_filt_reg <= rs_sync_reg[2];
			end
			if (en_sync_reg[1] == en_sync_reg[2]) begin
				en_filt_reg <= en_sync_reg[2];
			end
		end
	end

	// intent is compared only once steady, so sync latency raises no false mismatch
	assign intent_stable = (&intent_hist_reg) | (~|intent_hist_reg);
	assign mismatch = intent_stable & (rs_filt_reg != intent_hist_reg[INTENT_HIST-1]);
	assign warm_reset = mismatch & ~rs_filt_reg & intent_hist_reg[INTENT_HIST-1] & mm_rst_en;

	always_comb begin
		reset_source = power_on_reset_event | (dev_state == ST_OFF) | (dev_state == ST_RESET);
		reset_source = reset_source | uv_events[0] | (|(uv_events[4:1] & cfg_reg[IDX_SAFETY_CONFIG1][3:0]));
		reset_source = reset_source | (|(ov_events & cfg_reg[IDX_SAFETY_CONFIG3][4:0]));
		reset_source = reset_source | (cfg_reg[IDX_SAFETY_CONFIG5][BIT_WD_RST_EN]
			& (wdog_fail_count > cfg_reg[IDX_SAFETY_CONFIG4][7:4]));
		reset_source = reset_source | (cfg_reg[IDX_SAFETY_CONFIG5][BIT_MON_RST_EN]
			& (error_signal_monitor_fail_count > cfg_reg[IDX_SAFETY_CONFIG5][3:0]));
		reset_source = reset_source | (link.cmd_valid & (link.cmd_op == OP_SW_RESET)) | warm_reset;
	end

	always_comb begin
		case (ext_sel)
			2'h0: ext_load = EXT_CNT_W'(EXT0_CYC);
			2'h1: ext_load = EXT_CNT_W'(EXT1_CYC);
			2'h2: ext_load = EXT_CNT_W'(EXT2_CYC);
			default: ext_load = EXT_CNT_W'(EXT3_CYC);
		endcase
	end

	// reset comes up asserted, so the pin is low from the first moment
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ext_cnt_reg <= '0;
			reset_oe_reg <= 1'b1;
			intent_hist_reg <= '0;
		end else if (ce) begin
			if (reset_source) begin
				ext_cnt_reg <= ext_load;
			end else if (ext_cnt_reg != '0) begin
				ext_cnt_reg <= ext_cnt_reg - EXT_CNT_W'(1);
			end
			reset_oe_reg <= reset_source | (ext_cnt_reg != '0);
			intent_hist_reg <= {intent_hist_reg[INTENT_HIST-2:0], ~reset_oe_reg};
		end
	end

	assign link.reset_dev_out = 1'b0;
	assign link.reset_dev_oe = reset_oe_reg;
	assign reset_request = reset_oe_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			enable_out_ctrl <= 1'b0;
			enable_drive_reg <= 1'b0;
			drive_hist_reg <= '0;
		end else if (ce) begin
			if (!in_run) begin
				enable_out_ctrl <= 1'b0;
			end else if (link.cmd_valid && link.cmd_op == OP_ENABLE) begin
				if (!link.cmd_data[0]) begin
					enable_out_ctrl <= 1'b0;
				end else if (wdog_fail_count < cfg_reg[IDX_SAFETY_CONFIG4][3:0]) begin
					enable_out_ctrl <= 1'b1;
				end
			end
			enable_drive_reg <= enable_out_ctrl & in_run
				& ~(analog_builtin_self_test & (|cfg_reg[IDX_DEVICE_CONFIG1][2:0]));
			drive_hist_reg <= {drive_hist_reg[DRIVE_HIST-2:0], enable_drive_reg};
		end
	end

	assign link.enable_drive = enable_drive_reg;
	assign driver_error = (&drive_hist_reg) & enable_drive_reg & ~en_filt_reg;

	assign crc_in_bit = cfg_reg[crc_bit_reg[6:3]][~crc_bit_reg[2:0]];
	assign crc_next = {crc_reg[6:0], 1'b0} ^ ((crc_reg[7] ^ crc_in_bit) ? CRC_POLY : 8'h00);

	// a config write mid-pass restarts the pass rather than report a stale sum
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			crc_reg <= CRC_INIT;
			crc_bit_reg <= '0;
			crc_fail_reg <= 1'b0;
		end else if (ce) begin
			crc_fail_reg <= 1'b0;
			if (!crc_enable_reg || cfg_write) begin
				crc_reg <= CRC_INIT;
				crc_bit_reg <= '0;
			end else if (crc_bit_reg == CRC_LAST_BIT) begin
				crc_fail_reg <= crc_next != crc_expected_reg;
				crc_reg <= CRC_INIT;
				crc_bit_reg <= '0;
			end else begin
				crc_reg <= crc_next;
				crc_bit_reg <= crc_bit_reg + 7'h01;
			end
		end
	end

	always_comb begin
		flag_set = '0;
		flag_set[FLAG_MISMATCH] = mismatch;
		flag_set[FLAG_CRC] = crc_fail_reg;
		flag_set[FLAG_DRIVER] = driver_error;
		flag_clr = (link.cmd_valid && link.cmd_op == OP_CLEAR) ? link.cmd_data[FLAGS_W-1:0] : '0;
	end

	// set wins over clear in the same cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			flags_reg <= '0;
			safe_req_reg <= 1'b0;
		end else if (ce) begin
			flags_reg <= (flags_reg & ~flag_clr) | flag_set;
			safe_req_reg <= (mismatch & mm_safe_en & ~mm_rst_en)
				| (crc_fail_reg & (in_run | (dev_state == ST_RESET)));
		end
	end

	assign status_flags = flags_reg;
	assign safe_request = safe_req_reg;
	assign link.dev_flags = flags_reg;
endmodule

// ### srecc_assertions.sv
`timescale 1ns/1ps
module srecc_assertions (
	input wire logic clock,
	input wire logic rst,
	input wire logic reset_dev_out,
	input wire logic reset_dev_oe,
	input wire logic reset_host_out,
	input wire logic reset_host_oe,
	input wire logic enable_drive,
	input wire logic enable_pin_level,
	input wire logic cmd_valid,
	input wire srecc_pkg::srecc_op_type cmd_op,
	input wire logic [srecc_pkg::FLAGS_W-1:0] dev_flags
);
	import srecc_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence sw_cmd;
		cmd_valid && cmd_op == OP_SW_RESET;
	endsequence
	// 8 cycles covers the 3-stage sync plus the 5-cycle steadiness filter
	sequence forced_low;
		(reset_host_oe && !reset_dev_oe) [*8];
	endsequence
	sequence drive_fought;
		(enable_drive && !enable_pin_level) [*8];
	endsequence
	dev_open_drain_a: assert property (reset_dev_out == 1'b0)
		else $error("device drives reset pin high");
	host_open_drain_a: assert property (reset_host_out == 1'b0)
		else $error("host drives reset pin high");
	sw_reset_a: assert property (sw_cmd |=> reset_dev_oe)
		else $error("software reset not taken");
	ext_hold_a: assert property (sw_cmd |=> reset_dev_oe [*8])
		else $error("reset released too early");
	mismatch_flag_a: assert property (forced_low |-> ##[0:4] dev_flags[FLAG_MISMATCH])
		else $error("reset pin mismatch not flagged");
	driver_error_a: assert property (drive_fought |-> ##[0:4] dev_flags[FLAG_DRIVER])
		else $error("enable driver error not flagged");
	flag_sticky_a: assert property ((($past(dev_flags) & ~dev_flags) != '0)
		|-> $past(cmd_valid && cmd_op == OP_CLEAR))
		else $error("flag dropped without clear");
	cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
		else $error("command pulse longer than one cycle");
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import srecc_pkg::*;
	logic clock, rst, ce, avs_read, avs_write, por_ev, self_test, safe_request, enable_out_ctrl, safe_seen;
	logic avs_waitrequest, reset_request;
	logic [3:0] avs_address, wdog_cnt, mon_cnt;
	logic [31:0] avs_writedata, avs_readdata, q;
	logic [4:0] uv, ov;
	logic [FLAGS_W-1:0] status_flags;
	srecc_state_type st;
	logic [7:0] cfg [16];
	int n_fail, n_checks;
	srecc_link_if srecc_link_if_i();
	wire pin = srecc_link_if_i.reset_level;
	wire drv = srecc_link_if_i.enable_drive;
	srecc_host srecc_host_i(.clock(clock), .rst(rst), .ce(ce), .link(srecc_link_if_i),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	srecc_device srecc_device_i(.clock(clock), .rst(rst), .ce(ce), .link(srecc_link_if_i), .dev_state(st),
		.power_on_reset_event(por_ev), .uv_events(uv), .ov_events(ov), .wdog_fail_count(wdog_cnt),
		.error_signal_monitor_fail_count(mon_cnt), .analog_builtin_self_test(self_test),
		.reset_request(reset_request), .safe_request(safe_request), .enable_out_ctrl(enable_out_ctrl),
		.status_flags(status_flags));
	srecc_assertions srecc_assertions_i(.clock(clock), .rst(rst),
		.reset_dev_out(srecc_link_if_i.reset_dev_out), .reset_dev_oe(srecc_link_if_i.reset_dev_oe),
		.reset_host_out(srecc_link_if_i.reset_host_out), .reset_host_oe(srecc_link_if_i.reset_host_oe),
		.enable_drive(srecc_link_if_i.enable_drive), .enable_pin_level(srecc_link_if_i.enable_pin_level),
		.cmd_valid(srecc_link_if_i.cmd_valid), .cmd_op(srecc_link_if_i.cmd_op),
		.dev_flags(srecc_link_if_i.dev_flags));
	// safe_request may be a single-cycle pulse, so it is caught here
	always @(posedge clock) if (safe_request === 1'b1) safe_seen <= 1'b1;
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input int v, input int lo, input int hi);
		n_checks++;
		if (v < lo || v > hi) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
		end
	endtask
	task automatic ticks(input int k);
		repeat (k) @(posedge clock);
	endtask
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 50);
		if (avs_waitrequest !== 1'b0) begin
			chk(32'h0, 32'h1);
			report_and_stop();
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// shadow tracks only writes the device is allowed to accept
	task automatic cmd(input srecc_op_type op, input logic [4:0] a, input logic [7:0] d);
		av(1'b1, AV_CMD, {14'h0000, op, 3'h0, a, d});
		if (op == OP_CFG_WRITE && st == ST_DIAG && a < 5'h10) cfg[a[3:0]] = d;
	endtask
	task automatic wait_pin(input logic v, output int c);
		c = 0;
		while (pin !== v && c < 2000) begin
			@(posedge clock);
			c++;
		end
		if (pin !== v) begin
			chk(32'(pin), 32'(v));
			report_and_stop();
		end
	endtask
	function automatic logic [7:0] crc8();
		logic [7:0] c;
		c = 8'hFF;
		for (int b = 0; b < 128; b++) c = {c[6:0], 1'b0} ^ ((c[7] ^ cfg[b / 8][7 - b % 8]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	task automatic t_por_ext();
		int c;
		int ext[4] = '{EXT0_CYC, EXT1_CYC, EXT2_CYC, EXT3_CYC};
		ticks(5);
		chk(32'(pin), 32'h0);
		por_ev <= 1'b0;
		wait_pin(1'b1, c);
		chk_rng(c, EXT0_CYC, EXT0_CYC + 6);
		for (int s = 0; s < 4; s++) begin
			cmd(OP_CFG_WRITE, 5'h03, 8'(s));
			cmd(OP_SW_RESET, 5'h00, 8'h00);
			wait_pin(1'b0, c);
			chk_rng(c, 0, 2);
			wait_pin(1'b1, c);
			chk_rng(c, ext[s], ext[s] + 6);
		end
		cmd(OP_CFG_WRITE, 5'h03, 8'h00);
		$display("reset extension test done");
	endtask
	task automatic pulse(input int k, input logic exp);
		int c;
		if (k < 5) uv <= 5'(1 << k);
		else if (k < 10) ov <= 5'(1 << (k - 5));
		else if (k == 10) wdog_cnt <= 4'h3;
		else if (k == 11) mon_cnt <= 4'h3;
		else st <= (k == 12) ? ST_OFF : ST_RESET;
		ticks(4);
		chk(32'(reset_request), 32'(exp));
		uv <= 5'h00;
		ov <= 5'h00;
		wdog_cnt <= 4'h0;
		mon_cnt <= 4'h0;
		st <= ST_DIAG;
		wait_pin(1'b1, c);
	endtask
	task automatic t_srcs();
		cmd(OP_CFG_WRITE, 5'h07, 8'h25);
		cmd(OP_CFG_WRITE, 5'h08, 8'h02);
		for (int k = 0; k < 12; k++) pulse(k, k == 0);
		cmd(OP_CFG_WRITE, 5'h04, 8'h0F);
		cmd(OP_CFG_WRITE, 5'h06, 8'h1F);
		cmd(OP_CFG_WRITE, 5'h08, 8'h32);
		for (int k = 0; k < 14; k++) pulse(k, 1'b1);
		cmd(OP_CFG_WRITE, 5'h04, 8'h00);
		cmd(OP_CFG_WRITE, 5'h06, 8'h00);
		cmd(OP_CFG_WRITE, 5'h07, 8'hF5);
		cmd(OP_CFG_WRITE, 5'h08, 8'h00);
		$display("reset source test done");
	endtask
	task automatic force_low(input logic [7:0] en);
		int c;
		cmd(OP_CFG_WRITE, 5'h05, en);
		safe_seen = 1'b0;
		av(1'b1, AV_PIN, 32'h1);
		ticks(14);
		av(1'b0, AV_STATUS, 32'h0);
		chk(32'(q[STAT_FLAGS_LSB + FLAG_MISMATCH]), 32'h1);
		chk(32'(q[STAT_RESET_PIN]), 32'h0);
		chk(32'(safe_seen), 32'(en == 8'h02));
		chk(32'(reset_request), 32'(en == 8'h01));
		av(1'b1, AV_PIN, 32'h0);
		wait_pin(1'b1, c);
		ticks(8);
		cmd(OP_CLEAR, 5'h00, 8'h07);
		ticks(2);
		chk(32'(status_flags), 32'h0);
	endtask
	task automatic t_enable();
		wdog_cnt <= 4'h5;
		cmd(OP_ENABLE, 5'h00, 8'h01);
		ticks(3);
		chk(32'(enable_out_ctrl), 32'h0);
		wdog_cnt <= 4'h4;
		cmd(OP_ENABLE, 5'h00, 8'h01);
		ticks(3);
		chk(32'({enable_out_ctrl, drv}), 32'h3);
		self_test <= 1'b1;
		ticks(3);
		chk(32'(drv), 32'h1);
		av(1'b0, AV_STATUS, 32'h0);
		chk(32'(q[STAT_ENABLE_PIN]), 32'h1);
		self_test <= 1'b0;
		cmd(OP_CFG_WRITE, 5'h00, 8'h04);
		self_test <= 1'b1;
		ticks(3);
		chk(32'({enable_out_ctrl, drv}), 32'h2);
		self_test <= 1'b0;
		ticks(3);
		chk(32'(drv), 32'h1);
		srecc_link_if_i.enable_ext_low <= 1'b1;
		ticks(12);
		chk(32'(status_flags[FLAG_DRIVER]), 32'h1);
		srecc_link_if_i.enable_ext_low <= 1'b0;
		st <= ST_ACTIVE;
		ticks(3);
		chk(32'(drv), 32'h1);
		st <= ST_SAFE;
		ticks(3);
		chk(32'({enable_out_ctrl, drv}), 32'h0);
		cmd(OP_ENABLE, 5'h00, 8'h01);
		ticks(3);
		chk(32'(enable_out_ctrl), 32'h0);
		st <= ST_DIAG;
		wdog_cnt <= 4'h0;
		cmd(OP_CFG_WRITE, 5'h00, 8'h00);
		cmd(OP_CLEAR, 5'h00, 8'h07);
		$display("enable output test done");
	endtask
	task automatic t_crc();
		logic [7:0] e;
		cmd(OP_CFG_WRITE, 5'h01, 8'hA5);
		cmd(OP_CFG_WRITE, 5'h0F, 8'h3C);
		e = crc8();
		cmd(OP_CFG_WRITE, 5'h10, e);
		cmd(OP_CFG_WRITE, 5'h11, 8'h01);
		ticks(300);
		chk(32'(status_flags[FLAG_CRC]), 32'h0);
		safe_seen = 1'b0;
		cmd(OP_CFG_WRITE, 5'h10, e ^ 8'h01);
		ticks(300);
		chk(32'({status_flags[FLAG_CRC], safe_seen}), 32'h3);
		cmd(OP_CFG_WRITE, 5'h10, e);
		cmd(OP_CLEAR, 5'h00, 8'h07);
		st <= ST_ACTIVE;
		cmd(OP_CFG_WRITE, 5'h01, 8'h00);
		ticks(300);
		chk(32'(status_flags[FLAG_CRC]), 32'h0);
		st <= ST_DIAG;
		cmd(OP_CFG_WRITE, 5'h11, 8'h00);
		$display("config crc test done");
	endtask
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		{avs_read, avs_write, self_test, safe_seen} = 4'h0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		{uv, ov, wdog_cnt, mon_cnt} = 18'h00000;
		srecc_link_if_i.enable_ext_low = 1'b0;
		st = ST_DIAG;
		por_ev = 1'b1;
		for (int k = 0; k < 16; k++) cfg[k] = 8'h00;
		cfg[7] = 8'hF5;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		t_por_ext();
		t_srcs();
		force_low(8'h00);
		force_low(8'h02);
		force_low(8'h01);
		cmd(OP_CFG_WRITE, 5'h05, 8'h00);
		t_enable();
		t_crc();
		report_and_stop();
	end
endmodule
